// ===== csc_consts.svh
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH

// width of the core-to-bus frequency ratio strap word
`define CSC_RATIO_W 3
// ratio shown before the first bus reset release has been seen
`define CSC_RATIO_RST 3'h0
// strap word bit positions
`define CSC_STRAP_IGN 2
`define CSC_STRAP_LP1 1
`define CSC_STRAP_LP0 0
// designated machine check edges come on this phase value
`define CSC_MCE_PHASE 1'h0
// host keeps strap levels this many cycles after releasing bus reset
`define CSC_STRAP_HOLD 3'h4
// width of the device input synchroniser
`define CSC_SYNC_W 6
// synchroniser bit positions
`define CSC_SY_RST 0
`define CSC_SY_INIT 1
`define CSC_SY_IGN 2
`define CSC_SY_LP0 3
`define CSC_SY_LP1 4
`define CSC_SY_RESTART 5

`endif

// ===== csc_pkg.sv
`include "csc_consts.svh"

package csc_pkg;

  typedef logic [`CSC_RATIO_W-1:0] csc_ratio_t;
  typedef logic [`CSC_SYNC_W-1:0]  csc_sync_t;

  typedef enum logic [1:0] {
    CSC_LK_IDLE,
    CSC_LK_HELD
  } csc_lock_e;

  typedef enum logic [1:0] {
    CSC_AR_IDLE,
    CSC_AR_WAIT,
    CSC_AR_OWN
  } csc_arb_e;

endpackage

// ===== csc_if.sv
interface csc_if;
  logic       bus_reset;
  logic       warm_restart;
  logic       numeric_error_ignore;
  logic [1:0] local_interrupt_pins;
  logic       bus_restart;
  logic       target_ready;
  logic       priority_agent_request;
  logic       lock;
  logic       internal_error_out;
  logic       dev_mce_o;
  logic       dev_mce_oe;
  logic       host_mce_o;
  logic       host_mce_oe;
  logic       machine_check_error;

  // wired-or: the line is active while any agent drives it active
  assign machine_check_error = (dev_mce_oe & dev_mce_o) | (host_mce_oe & host_mce_o);

  modport dev (
    input  bus_reset,
    input  warm_restart,
    input  numeric_error_ignore,
    input  local_interrupt_pins,
    input  bus_restart,
    input  target_ready,
    input  priority_agent_request,
    input  machine_check_error,
    output lock,
    output internal_error_out,
    output dev_mce_o,
    output dev_mce_oe
  );

  modport host (
    output bus_reset,
    output warm_restart,
    output numeric_error_ignore,
    output local_interrupt_pins,
    output bus_restart,
    output target_ready,
    output priority_agent_request,
    output host_mce_o,
    output host_mce_oe,
    input  lock,
    input  internal_error_out,
    input  machine_check_error
  );
endinterface

// ===== csc_sync2.sv
module csc_sync2 (
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  input  wire csc_pkg::csc_sync_t i_async,
  output csc_pkg::csc_sync_t      o_sync
);
  import csc_pkg::*;

  typedef struct packed {
    csc_sync_t s1;
    csc_sync_t s2;
  } csc_sy_s;

  csc_sy_s r_r;
  csc_sy_s r_nxt;

  always_comb
  begin
    r_nxt    = r_r;
    r_nxt.s1 = i_async;
    r_nxt.s2 = r_r.s1;
    if (i_sys_rst)
    begin
      r_nxt = '0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    r_r <= r_nxt;
  end

  assign o_sync = r_r.s2;
endmodule

// ===== csc_device.sv
`include "csc_consts.svh"

// Function
// - ignore input set lets pending fp error pass
// - ignore clear: pending error traps noncontrol fp
// - ignore input has no effect while enable bit set
// - host holds ignore valid at target ready
// - ignore and lint straps set frequency ratio
// - warm restart resets integers, restarts at vector
// - snoops keep running during warm restart
// - warm restart at reset release starts self-test
// - controller off: pin 0 maskable, pin 1 nonmaskable
// - controller enabled after reset until firmware writes
// - lock held first start to last end
// - priority agent waits for lock release
// - unrecoverable error drives machine check line when machine check enable set
// - machine check enable, with internal error, initiator
// - observed bus transaction error drives machine check
// - machine check driven, sampled on designated edges
// - internal error sticks until reset, restart, init
module csc_device (
  input  wire logic                i_ref_clk,
  input  wire logic                i_sys_rst,
  csc_if.dev                       bus,
  input  wire logic                i_numeric_error_enable_bit,
  input  wire logic                i_fp_issue,
  input  wire logic                i_fp_err_pend,
  input  wire logic                i_lic_wr,
  input  wire logic                i_lic_en_val,
  input  wire logic                i_lock_first_start,
  input  wire logic                i_lock_last_end,
  input  wire logic                i_internal_error,
  input  wire logic                i_unrecoverable,
  input  wire logic                i_initiator_error,
  input  wire logic                i_bus_error_seen,
  input  wire logic                i_mce_enable,
  input  wire logic                i_mce_on_int_error,
  input  wire logic                i_mce_on_init,
  output logic                     o_fp_exception,
  output logic                     o_fp_continue,
  output csc_pkg::csc_ratio_t      o_freq_ratio,
  output logic                     o_self_test_start,
  output logic                     o_int_reg_reset,
  output logic                     o_vector_start,
  output logic                     o_snoop_enable,
  output logic                     o_lic_enabled,
  output logic [1:0]               o_local_int,
  output logic                     o_maskable_interrupt_request,
  output logic                     o_nonmaskable_interrupt,
  output logic                     o_mce_seen
);
  import csc_pkg::*;

  typedef struct packed {
    logic       rst_d;
    logic       init_d;
    csc_ratio_t ratio;
    logic       self_test;
    logic       warm;
    logic       vec;
    logic       snoop;
    logic       lic_en;
    logic [1:0] lpin;
    logic       mask_req;
    logic       nmi;
    logic       fp_exc;
    logic       fp_cont;
    csc_lock_e  lk;
    logic       lock;
    logic       int_err;
    logic       phase;
    logic       mce_pend;
    logic       mce_drv;
    logic       mce_seen;
  } csc_dev_s;

  csc_dev_s  st_r;
  csc_dev_s  st_nxt;
  csc_sync_t sy_in;
  csc_sync_t sy;
  logic      s_rst;
  logic      s_init;
  logic      s_ign;
  logic      s_restart;
  logic [1:0] s_lpin;
  logic      ign_eff;
  logic      rst_fall;
  logic      mce_evt;

  //////////////////////////////////////////////////////////////////////
  // input synchroniser

  assign sy_in[`CSC_SY_RST]     = bus.bus_reset;
  assign sy_in[`CSC_SY_INIT]    = bus.warm_restart;
  assign sy_in[`CSC_SY_IGN]     = bus.numeric_error_ignore;
  assign sy_in[`CSC_SY_LP0]     = bus.local_interrupt_pins[0];
  assign sy_in[`CSC_SY_LP1]     = bus.local_interrupt_pins[1];
  assign sy_in[`CSC_SY_RESTART] = bus.bus_restart;

  csc_sync2 i_csc_sync2 (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (sy_in),
    .o_sync    (sy)
  );

  assign s_rst   = sy[`CSC_SY_RST];
  assign s_init  = sy[`CSC_SY_INIT];
  assign s_ign   = sy[`CSC_SY_IGN];
  assign s_restart = sy[`CSC_SY_RESTART];
  assign s_lpin    = {sy[`CSC_SY_LP1], sy[`CSC_SY_LP0]};

  //////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rst_d  = s_rst;
    st_nxt.init_d = s_init;
    rst_fall      = st_r.rst_d & ~s_rst;

    // configuration straps caught as bus reset releases
    if (rst_fall)
    begin
      st_nxt.ratio = {s_ign, s_lpin};
    end
    st_nxt.self_test = rst_fall & s_init;

    // warm restart
    st_nxt.warm  = s_init;
    st_nxt.vec   = st_r.init_d & ~s_init & ~s_rst;
    st_nxt.snoop = ~s_rst;

    // local interrupt controller enable
    if (s_rst)
    begin
      st_nxt.lic_en = 1'b1;
    end
    else if (i_lic_wr)
    begin
      st_nxt.lic_en = i_lic_en_val;
    end
    st_nxt.lpin     = st_r.lic_en ? s_lpin : 2'h0;
    st_nxt.mask_req = ~st_r.lic_en & s_lpin[0];
    st_nxt.nmi      = ~st_r.lic_en & s_lpin[1];

    // numeric error handling
    ign_eff        = s_ign & ~i_numeric_error_enable_bit;
    st_nxt.fp_exc  = i_fp_issue & i_fp_err_pend & ~ign_eff;
    st_nxt.fp_cont = i_fp_issue & (~i_fp_err_pend | ign_eff);

    // locked sequence
    unique case (st_r.lk)
      CSC_LK_IDLE:
      begin
        if (i_lock_first_start)
        begin
          st_nxt.lk = CSC_LK_HELD;
        end
      end
      CSC_LK_HELD:
      begin
        if (i_lock_last_end)
        begin
          st_nxt.lk = CSC_LK_IDLE;
        end
      end
      default:
      begin
        st_nxt.lk = CSC_LK_IDLE;
      end
    endcase
    if (s_rst)
    begin
      st_nxt.lk = CSC_LK_IDLE;
    end
    st_nxt.lock = (st_nxt.lk == CSC_LK_HELD);

    // internal error, sticky
    if (s_rst | s_restart | s_init)
    begin
      st_nxt.int_err = 1'b0;
    end
    else if (i_internal_error)
    begin
      st_nxt.int_err = 1'b1;
    end

    // machine check error
    mce_evt = i_bus_error_seen
            | (i_mce_enable & i_unrecoverable)
            | (i_mce_enable & i_mce_on_int_error & i_internal_error)
            | (i_mce_enable & i_mce_on_init & i_initiator_error);
    st_nxt.phase = ~st_r.phase;
    if (st_r.phase == `CSC_MCE_PHASE)
    begin
      st_nxt.mce_drv  = st_r.mce_pend;
      st_nxt.mce_pend = mce_evt;
      st_nxt.mce_seen = bus.machine_check_error;
    end
    else if (mce_evt)
    begin
      st_nxt.mce_pend = 1'b1;
    end

    if (i_sys_rst)
    begin
      st_nxt        = '0;
      st_nxt.ratio  = `CSC_RATIO_RST;
      st_nxt.lk     = CSC_LK_IDLE;
      st_nxt.lic_en = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    st_r <= st_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign bus.lock                     = st_r.lock;
  assign bus.internal_error_out       = st_r.int_err;
  assign bus.dev_mce_o                = st_r.mce_drv;
  assign bus.dev_mce_oe               = st_r.mce_drv;
  assign o_fp_exception               = st_r.fp_exc;
  assign o_fp_continue                = st_r.fp_cont;
  assign o_freq_ratio                 = st_r.ratio;
  assign o_self_test_start            = st_r.self_test;
  assign o_int_reg_reset              = st_r.warm;
  assign o_vector_start               = st_r.vec;
  assign o_snoop_enable               = st_r.snoop;
  assign o_lic_enabled                = st_r.lic_en;
  assign o_local_int                  = st_r.lpin;
  assign o_maskable_interrupt_request = st_r.mask_req;
  assign o_nonmaskable_interrupt      = st_r.nmi;
  assign o_mce_seen                   = st_r.mce_seen;
endmodule

// ===== csc_host.sv
`include "csc_consts.svh"

module csc_host (
  input  wire logic                i_ref_clk,
  input  wire logic                i_sys_rst,
  csc_if.host                      bus,
  input  wire logic                i_bus_reset,
  input  wire logic                i_warm_restart,
  input  wire logic                i_bus_restart,
  input  wire logic                i_ignore,
  input  wire logic [1:0]          i_lpins,
  input  wire csc_pkg::csc_ratio_t i_strap,
  input  wire logic                i_io_write,
  input  wire logic                i_prio_want,
  input  wire logic                i_host_error,
  output logic                     o_bus_granted,
  output logic                     o_lock_seen,
  output logic                     o_internal_error,
  output logic                     o_mce_seen
);
  import csc_pkg::*;

  typedef struct packed {
    logic       rst;
    logic       init;
    logic       restart;
    logic       ign;
    logic [1:0] lpin;
    logic [2:0] hold;
    logic       tready;
    csc_arb_e   arb;
    logic       prio;
    logic       grant;
    logic       phase;
    logic       mce_pend;
    logic       mce_drv;
    logic       mce_seen;
    logic       lock_seen;
    logic       int_err_seen;
  } csc_host_s;

  csc_host_s st_r;
  csc_host_s st_nxt;
  logic      strap_on;

  //////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.rst   = i_bus_reset;
    st_nxt.init  = i_warm_restart;
    st_nxt.restart = i_bus_restart;

    // straps driven through reset and a few cycles past its release
    if (i_bus_reset)
    begin
      st_nxt.hold = `CSC_STRAP_HOLD;
    end
    else if (st_r.hold != 3'h0)
    begin
      st_nxt.hold = st_r.hold - 3'h1;
    end
    strap_on = i_bus_reset | (st_r.hold != 3'h0);
    if (strap_on)
    begin
      st_nxt.ign  = i_strap[`CSC_STRAP_IGN];
      st_nxt.lpin = {i_strap[`CSC_STRAP_LP1], i_strap[`CSC_STRAP_LP0]};
    end
    else
    begin
      st_nxt.ign  = i_ignore;
      st_nxt.lpin = i_lpins;
    end
    st_nxt.tready = i_io_write & ~strap_on;

    // priority agent arbitration
    unique case (st_r.arb)
      CSC_AR_IDLE:
      begin
        if (i_prio_want)
        begin
          st_nxt.arb  = CSC_AR_WAIT;
          st_nxt.prio = 1'b1;
        end
      end
      CSC_AR_WAIT:
      begin
        if (!bus.lock)
        begin
          st_nxt.arb   = CSC_AR_OWN;
          st_nxt.grant = 1'b1;
        end
      end
      CSC_AR_OWN:
      begin
        if (!i_prio_want)
        begin
          st_nxt.arb   = CSC_AR_IDLE;
          st_nxt.prio  = 1'b0;
          st_nxt.grant = 1'b0;
        end
      end
      default:
      begin
        st_nxt.arb   = CSC_AR_IDLE;
        st_nxt.prio  = 1'b0;
        st_nxt.grant = 1'b0;
      end
    endcase

    // machine check error on designated edges
    st_nxt.phase = ~st_r.phase;
    if (st_r.phase == `CSC_MCE_PHASE)
    begin
      st_nxt.mce_drv  = st_r.mce_pend;
      st_nxt.mce_pend = i_host_error;
      st_nxt.mce_seen = bus.machine_check_error;
    end
    else if (i_host_error)
    begin
      st_nxt.mce_pend = 1'b1;
    end
    st_nxt.lock_seen = bus.lock;
    st_nxt.int_err_seen = bus.internal_error_out;

    if (i_sys_rst)
    begin
      st_nxt     = '0;
      st_nxt.rst = 1'b1;
      st_nxt.arb = CSC_AR_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    st_r <= st_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign bus.bus_reset              = st_r.rst;
  assign bus.warm_restart           = st_r.init;
  assign bus.bus_restart            = st_r.restart;
  assign bus.numeric_error_ignore   = st_r.ign;
  assign bus.local_interrupt_pins   = st_r.lpin;
  assign bus.target_ready           = st_r.tready;
  assign bus.priority_agent_request = st_r.prio;
  assign bus.host_mce_o             = st_r.mce_drv;
  assign bus.host_mce_oe            = st_r.mce_drv;
  assign o_bus_granted              = st_r.grant;
  assign o_lock_seen                = st_r.lock_seen;
  assign o_internal_error           = st_r.int_err_seen;
  assign o_mce_seen                 = st_r.mce_seen;
endmodule

// ===== csc_properties.sv
module csc_properties (
  input wire logic       i_ref_clk,
  input wire logic       i_sys_rst,
  input wire logic       bus_reset,
  input wire logic       warm_restart,
  input wire logic       numeric_error_ignore,
  input wire logic [1:0] local_interrupt_pins,
  input wire logic       bus_restart,
  input wire logic       lock,
  input wire logic       internal_error_out,
  input wire logic       dev_mce_o,
  input wire logic       dev_mce_oe,
  input wire logic       machine_check_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // cycles since any clear source was last high
  logic       clr_src;
  logic [3:0] clr_age_r;

  assign clr_src = bus_reset | bus_restart | warm_restart;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || clr_src)
      clr_age_r <= 4'h0;
    else if (clr_age_r != 4'hf)
      clr_age_r <= clr_age_r + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_int_err_cause:
    assert property ($fell(internal_error_out) |-> clr_age_r <= 4'h4)
    else $error("internal error dropped with no clear source");
  a_int_err_hold:
    assert property (internal_error_out && !clr_src && clr_age_r > 4'h4 |=> internal_error_out)
    else $error("internal error did not hold");
  a_int_err_flush:
    assert property (clr_src [*5] |-> !internal_error_out)
    else $error("internal error not cleared");
  a_lock_flush:
    assert property (bus_reset [*5] |-> !lock)
    else $error("lock held through bus reset");
  a_mce_edges:
    assert property ($changed(machine_check_error) |=> $stable(machine_check_error))
    else $error("machine check line moved off a designated edge");
  a_mce_width:
    assert property ($rose(dev_mce_oe) |-> dev_mce_o ##1 (dev_mce_oe && dev_mce_o))
    else $error("machine check drive too short");
  a_drive_edges:
    assert property ($changed(dev_mce_oe) |=> $stable(dev_mce_oe))
    else $error("device drive moved off a designated edge");
  a_strap_hold:
    assert property ($fell(bus_reset) |-> ($stable(numeric_error_ignore) && $stable(local_interrupt_pins)) [*4])
    else $error("straps changed after bus reset release");
endmodule

// ===== cpu_sideband_control_test.sv
module cpu_sideband_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import csc_pkg::*;

  logic       i_ref_clk, i_sys_rst;
  logic       fp_en, fp_issue, fp_pend, lic_wr, lic_en, lk_start, lk_end;
  logic [4:0] ev;
  logic [2:0] mce_cfg, strap;
  logic       h_brst, h_warm, h_restart, h_ign, h_io, h_prio;
  logic [1:0] h_lpin, lpin_out;
  logic       fp_exc, fp_cont, self_test, intrst, vec, snoop, lic_on, mir, nmi, d_mce;
  logic       granted, lock_seen, int_err, h_mce;
  csc_ratio_t ratio;
  int         num_errors = 0, samples_checked = 0, cycles = 0, st_cnt = 0, vec_cnt = 0;

  csc_if bus ();

  csc_device i_csc_device (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .bus(bus),
    .i_numeric_error_enable_bit(fp_en), .i_fp_issue(fp_issue), .i_fp_err_pend(fp_pend), .i_lic_wr(lic_wr),
    .i_lic_en_val(lic_en), .i_lock_first_start(lk_start), .i_lock_last_end(lk_end), .i_internal_error(ev[2]),
    .i_unrecoverable(ev[1]), .i_initiator_error(ev[3]), .i_bus_error_seen(ev[0]), .i_mce_enable(mce_cfg[0]),
    .i_mce_on_int_error(mce_cfg[1]), .i_mce_on_init(mce_cfg[2]), .o_fp_exception(fp_exc),
    .o_fp_continue(fp_cont), .o_freq_ratio(ratio), .o_self_test_start(self_test), .o_int_reg_reset(intrst),
    .o_vector_start(vec), .o_snoop_enable(snoop), .o_lic_enabled(lic_on), .o_local_int(lpin_out),
    .o_maskable_interrupt_request(mir), .o_nonmaskable_interrupt(nmi), .o_mce_seen(d_mce));

  csc_host i_csc_host (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .bus(bus), .i_bus_reset(h_brst),
    .i_warm_restart(h_warm), .i_bus_restart(h_restart), .i_ignore(h_ign), .i_lpins(h_lpin), .i_strap(strap),
    .i_io_write(h_io), .i_prio_want(h_prio), .i_host_error(ev[4]), .o_bus_granted(granted),
    .o_lock_seen(lock_seen), .o_internal_error(int_err), .o_mce_seen(h_mce));

  csc_properties i_csc_properties (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .bus_reset(bus.bus_reset),
    .warm_restart(bus.warm_restart), .numeric_error_ignore(bus.numeric_error_ignore),
    .local_interrupt_pins(bus.local_interrupt_pins), .bus_restart(bus.bus_restart), .lock(bus.lock),
    .internal_error_out(bus.internal_error_out), .dev_mce_o(bus.dev_mce_o), .dev_mce_oe(bus.dev_mce_oe),
    .machine_check_error(bus.machine_check_error));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (self_test === 1'b1)
      st_cnt++;
    if (vec === 1'b1)
      vec_cnt++;
    if (cycles == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected value at %0t: got %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // ignore level crosses host pin and device synchroniser before the issue
  task automatic fp_try(input logic ign, input logic ne, input logic exc);
    step(1);
    h_ign <= ign;
    fp_en <= ne;
    h_io <= 1'b1;
    step(1);
    h_io <= 1'b0;
    step(8);
    fp_issue <= 1'b1;
    step(1);
    fp_issue <= 1'b0;
    #1;
    check({1'b0, fp_exc, fp_cont}, {1'b0, exc, !exc});
  endtask

  // event bits: bus error, unrecoverable, internal, initiator, host
  task automatic mce_try(input logic [4:0] e, input logic [2:0] cfg, input logic exp);
    logic [1:0] hit;
    step(1);
    mce_cfg <= cfg;
    ev <= e;
    step(1);
    ev <= 5'h00;
    hit = 2'h0;
    repeat (8)
    begin
      step(1);
      #1;
      hit = hit | {d_mce, h_mce};
    end
    check({1'b0, hit}, {1'b0, exp, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {fp_en, fp_issue, lic_wr, lk_start, lk_end, h_restart, h_io, h_prio} = 8'h00;
    {ev, mce_cfg} = 8'h00;
    {i_sys_rst, h_brst, h_warm, h_ign, fp_pend, lic_en} = 6'h3f;
    h_lpin = 2'h1;
    strap = 3'h2;
    step(4);
    i_sys_rst <= 1'b0;
    step(6);
    h_brst <= 1'b0;
    step(10);
    #1;
    check({1'b0, intrst, snoop}, 3'h3);
    check({lpin_out, mir}, 3'h2);
    check({2'h0, lic_on}, 3'h1);
    step(1);
    h_warm <= 1'b0;
    step(10);
    #1;
    check(ratio, 3'h2);
    check({1'b0, st_cnt == 1, vec_cnt == 1}, 3'h3);
    fp_try(1'b1, 1'b0, 1'b0);
    fp_try(1'b0, 1'b0, 1'b1);
    fp_try(1'b1, 1'b1, 1'b1);
    fp_pend <= 1'b0;
    fp_try(1'b0, 1'b0, 1'b0);
    step(1);
    lic_wr <= 1'b1;
    lic_en <= 1'b0;
    step(1);
    lic_wr <= 1'b0;
    for (int v = 1; v < 4; v++)
    begin
      step(1);
      h_lpin <= v[1:0];
      step(8);
      #1;
      check({1'b0, nmi, mir}, {1'b0, v[1:0]});
      check({lpin_out, lic_on}, 3'h0);
    end
    step(1);
    lk_start <= 1'b1;
    step(1);
    lk_start <= 1'b0;
    h_prio <= 1'b1;
    step(6);
    #1;
    check({1'b0, lock_seen, granted}, 3'h2);
    step(1);
    lk_end <= 1'b1;
    step(1);
    lk_end <= 1'b0;
    for (int k = 0; k < 10 && granted !== 1'b1; k++)
      step(1);
    #1;
    check({1'b0, lock_seen, granted}, 3'h1);
    step(1);
    h_prio <= 1'b0;
    mce_try(5'h02, 3'h0, 1'b0);
    mce_try(5'h01, 3'h0, 1'b1);
    mce_try(5'h02, 3'h1, 1'b1);
    mce_try(5'h04, 3'h1, 1'b0);
    mce_try(5'h04, 3'h3, 1'b1);
    mce_try(5'h08, 3'h1, 1'b0);
    mce_try(5'h08, 3'h5, 1'b1);
    mce_try(5'h10, 3'h0, 1'b1);
    step(10);
    #1;
    check({2'h0, int_err}, 3'h1);
    step(1);
    h_restart <= 1'b1;
    step(2);
    h_restart <= 1'b0;
    step(8);
    #1;
    check({2'h0, int_err}, 3'h0);
    print_verdict();
  end
endmodule
